// File: rfsb_pkg.sv
// shared constants and types for the radio status and buffer block
package rfsb_pkg;

    // ------------------------------------------------------------
    // serial command decode
    // ------------------------------------------------------------
    localparam logic [4:0] CMD_BITS       = 5'h10;
    localparam logic [4:0] CMD_LAST_IDX   = 5'h0f;
    localparam logic [7:0] CMD_TX_WRITE   = 8'hb8;
    localparam logic [7:0] CMD_FIFO_READ  = 8'hb0;
    localparam logic [4:0] STATUS_BITS    = 5'h13;
    localparam logic [4:0] STATUS_LEFT    = 5'h12;
    localparam int         STATUS_MSB     = 18;

    // ------------------------------------------------------------
    // transmit data registers
    // ------------------------------------------------------------
    localparam logic [7:0] TX_INIT_BYTE   = 8'haa;
    localparam logic [2:0] TX_LAST_BIT    = 3'h7;

    // ------------------------------------------------------------
    // receive fifo
    // ------------------------------------------------------------
    localparam int         FIFO_DEPTH     = 16;
    localparam int         FIFO_AW        = 4;
    localparam int         FIFO_CW        = 5;

    // ------------------------------------------------------------
    // pins: {sck, sdi, cmd_select_n, fifo_select_n, ext_irq_n}
    // ------------------------------------------------------------
    localparam int         PIN_COUNT      = 5;
    localparam logic [4:0] PIN_IDLE       = 5'h07;
    localparam int         PIN_SCK        = 4;
    localparam int         PIN_SDI        = 3;
    localparam int         PIN_SEL_N      = 2;
    localparam int         PIN_FFS_N      = 1;
    localparam int         PIN_EXT_N      = 0;

    // latched flags: {por, underrun, overflow, wake, ext}
    localparam logic [4:0] LATCH_RESET    = 5'h10;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_CMD  = 3'b001,
        S_STAT = 3'b011,
        S_FIFO = 3'b010,
        S_IGN  = 3'b110
    } rfsb_state_t;

    // status word, shifted out msb first
    typedef struct packed {
        logic       tx_ready_flag;
        logic       rx_level_flag;
        logic       por_flag;
        logic       tx_underrun_flag;
        logic       rx_overflow_flag;
        logic       wake_timer_flag;
        logic       ext_pin_flag;
        logic       low_supply_flag;
        logic       rx_empty_flag;
        logic       antenna_signal_flag;
        logic       rssi_flag;
        logic       quality_detect_flag;
        logic       recovery_lock_flag;
        logic       offset_cycle_toggle;
        logic       offset_sign;
        logic [3:0] offset_low;
    } rfsb_status_t;

    // live indications from the radio, same clock domain
    typedef struct packed {
        logic low_supply;
        logic antenna_signal;
        logic rssi_above;
        logic quality_detect;
        logic recovery_lock;
        logic valid_data_indication;
        logic sync_match;
    } rfsb_radio_t;

    // configuration bits held by the other command registers
    typedef struct packed {
        logic       tx_buffer_enable;
        logic       tx_start_enable;
        logic [3:0] fifo_level;
    } rfsb_cfg_t;

endpackage

// File: rfsb_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module rfsb_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         mclk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] meta_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_q <= RST_VAL;
            dout   <= RST_VAL;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// File: rfsb_bit_fifo.sv
// one-bit wide receive fifo, sixteen entries
`timescale 1ns/1ns
module rfsb_bit_fifo
    import rfsb_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 push,
    input  wire logic                 push_bit,
    input  wire logic                 pop,
    output logic                      head_bit,
    output logic [rfsb_pkg::FIFO_CW-1:0] count,
    output logic                      full,
    output logic                      empty
);
    logic                mem [FIFO_DEPTH];
    logic [FIFO_AW-1:0]  wr_q;
    logic [FIFO_AW-1:0]  rd_q;
    logic [FIFO_CW-1:0]  cnt_q;
    logic                do_push;
    logic                do_pop;

    // a push into a full fifo is dropped; the caller flags it
    assign do_push  = push & ~full;
    assign do_pop   = pop & ~empty;
    assign full     = (cnt_q == FIFO_CW'(FIFO_DEPTH));
    assign empty    = (cnt_q == '0);
    assign count    = cnt_q;
    assign head_bit = mem[rd_q] & ~empty;

    always_ff @(posedge mclk) begin
        if (do_push) begin
            mem[wr_q] <= push_bit;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_q + FIFO_AW'(do_push);
            rd_q  <= rd_q + FIFO_AW'(do_pop);
            cnt_q <= cnt_q + FIFO_CW'(do_push) - FIFO_CW'(do_pop);
        end
    end
endmodule

// File: rfsb_top.sv
// serial status read, buffered transmit registers and receive fifo
`timescale 1ns/1ns
module rfsb_top
    import rfsb_pkg::*;
(
    input  wire logic                 mclk,
    input  wire logic                 rst,
    input  wire logic                 sck,
    input  wire logic                 sdi,
    input  wire logic                 cmd_select_n,
    input  wire logic                 fifo_select_n,
    input  wire logic                 ext_irq_n,
    input  wire rfsb_pkg::rfsb_radio_t radio,
    input  wire logic [6:0]           freq_offset_field,
    input  wire logic                 afc_cycle_done,
    input  wire logic                 wake_timer_ovf,
    input  wire logic                 rx_bit_valid,
    input  wire logic                 rx_bit,
    input  wire logic                 tx_bit_tick,
    input  wire rfsb_pkg::rfsb_cfg_t  cfg,
    output logic                      sdo,
    output logic                      fifo_irq_n,
    output logic                      tx_bit
);
    import rfsb_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisation and edge detection
    // ------------------------------------------------------------
    logic [PIN_COUNT-1:0] pin_raw;
    logic [PIN_COUNT-1:0] pin_s;
    logic                 sck_s;
    logic                 sdi_s;
    logic                 sel;
    logic                 ffs_sel;
    logic                 ext_n_s;
    logic                 sck_prev_q;
    logic                 sel_prev_q;
    logic                 ext_prev_q;
    logic                 rise;
    logic                 sel_end;
    logic                 ext_fall;

    assign pin_raw = {sck, sdi, cmd_select_n, fifo_select_n, ext_irq_n};

    rfsb_sync #(
        .W       (PIN_COUNT),
        .RST_VAL (PIN_IDLE)
    ) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  (pin_raw),
        .dout (pin_s)
    );

    assign sck_s    = pin_s[PIN_SCK];
    assign sdi_s    = pin_s[PIN_SDI];
    assign sel      = ~pin_s[PIN_SEL_N];
    assign ffs_sel  = ~pin_s[PIN_FFS_N];
    assign ext_n_s  = pin_s[PIN_EXT_N];
    assign rise     = sck_s & ~sck_prev_q;
    assign sel_end  = ~sel & sel_prev_q;
    assign ext_fall = ~ext_n_s & ext_prev_q;

    always_ff @(posedge mclk) begin
        if (rst) begin
            sck_prev_q <= 1'b0;
            sel_prev_q <= 1'b0;
            ext_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            sel_prev_q <= sel;
            ext_prev_q <= ext_n_s;
        end
    end

    // ------------------------------------------------------------
    // command framing
    // ------------------------------------------------------------
    rfsb_state_t   state_q;
    rfsb_state_t   state_d;
    logic [4:0]    bit_cnt_q;
    logic [15:0]   cmd_q;
    logic [15:0]   cmd_next;
    logic          in_cmd;
    logic          first_bit;
    logic          cmd_full;
    logic          status_start;
    logic          tx_write;
    logic          fifo_cmd;

    assign in_cmd       = sel & (state_q == S_CMD);
    assign cmd_next     = {cmd_q[14:0], sdi_s};
    assign first_bit    = rise & in_cmd & (bit_cnt_q == '0);
    assign cmd_full     = rise & in_cmd & (bit_cnt_q == CMD_LAST_IDX);
    assign status_start = first_bit & ~sdi_s;
    assign tx_write     = cmd_full & (cmd_next[15:8] == CMD_TX_WRITE)
                        & cfg.tx_buffer_enable;
    assign fifo_cmd     = cmd_full & (cmd_next[15:8] == CMD_FIFO_READ);

    always_comb begin
        state_d = state_q;
        if (!sel) begin
            state_d = S_IDLE;
        end else begin
            case (state_q)
                S_IDLE: state_d = S_CMD;
                S_CMD: begin
                    if (status_start) begin
                        state_d = S_STAT;
                    end else if (cmd_full) begin
                        state_d = fifo_cmd ? S_FIFO : S_IGN;
                    end
                end
                S_STAT: state_d = S_STAT;
                S_FIFO: state_d = S_FIFO;
                S_IGN:  state_d = S_IGN;
                default: state_d = S_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_q   <= S_IDLE;
            bit_cnt_q <= '0;
            cmd_q     <= '0;
        end else begin
            state_q <= state_d;
            if (state_q == S_IDLE) begin
                bit_cnt_q <= '0;
            end else if (rise & in_cmd) begin
                bit_cnt_q <= bit_cnt_q + 5'h01;
                cmd_q     <= cmd_next;
            end
        end
    end

    // ------------------------------------------------------------
    // receive fifo
    // ------------------------------------------------------------
    logic                fill_armed_q;
    logic                push;
    logic                pop;
    logic                serial_pop;
    logic                direct_pop;
    logic                head_bit;
    logic [FIFO_CW-1:0]  fifo_count;
    logic                fifo_full;
    logic                fifo_empty;
    logic [FIFO_CW-1:0]  level;
    logic                level_hit;
    logic                rx_level_q;
    logic [4:0]          stat_left_q;

    // noise never enters: filling waits for valid data plus sync
    always_ff @(posedge mclk) begin
        if (rst) begin
            fill_armed_q <= 1'b0;
        end else begin
            fill_armed_q <= (radio.valid_data_indication & radio.sync_match)
                          | (fill_armed_q & radio.valid_data_indication);
        end
    end

    assign push       = rx_bit_valid & fill_armed_q;
    assign serial_pop = rise & sel & ((state_q == S_FIFO)
                      | ((state_q == S_STAT) & (stat_left_q == '0)));
    assign direct_pop = rise & ~sel & ffs_sel;
    assign pop        = serial_pop | direct_pop;
    assign level      = {1'b0, cfg.fifo_level};
    assign level_hit  = fifo_count >= level;

    rfsb_bit_fifo u_fifo (
        .mclk     (mclk),
        .rst      (rst),
        .push     (push),
        .push_bit (rx_bit),
        .pop      (pop),
        .head_bit (head_bit),
        .count    (fifo_count),
        .full     (fifo_full),
        .empty    (fifo_empty)
    );

    // a pop clears; the next cycle re-sets from the new count, else a
    // poller at threshold one would take one bit too many
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_level_q <= 1'b0;
            fifo_irq_n <= 1'b1;
        end else begin
            rx_level_q <= ~pop & (level_hit | rx_level_q);
            fifo_irq_n <= ~(fifo_count > level);
        end
    end

    // ------------------------------------------------------------
    // transmit data registers
    // ------------------------------------------------------------
    logic [7:0] tx_shift_q;
    logic [7:0] tx_hold_q;
    logic       hold_full_q;
    logic [2:0] tx_idx_q;
    logic       start_prev_q;
    logic       start_rise;
    logic       start_fall;
    logic       sending;
    logic       reload;
    logic       tx_ready;
    logic       underrun_set;

    assign start_rise   = cfg.tx_start_enable & ~start_prev_q;
    assign start_fall   = ~cfg.tx_start_enable & start_prev_q;
    assign sending      = cfg.tx_start_enable & start_prev_q;
    assign reload       = sending & tx_bit_tick & (tx_idx_q == TX_LAST_BIT);
    assign tx_ready     = cfg.tx_buffer_enable
                        & (~cfg.tx_start_enable | ~hold_full_q);
    // an empty hold at reload, or a write over a full hold while sending
    assign underrun_set = (reload & ~hold_full_q & ~tx_write)
                        | (tx_write & sending & hold_full_q & ~reload);

    always_ff @(posedge mclk) begin
        if (rst) begin
            tx_shift_q   <= TX_INIT_BYTE;
            tx_hold_q    <= TX_INIT_BYTE;
            hold_full_q  <= 1'b1;
            tx_idx_q     <= '0;
            tx_bit       <= 1'b0;
            start_prev_q <= 1'b0;
        end else begin
            start_prev_q <= cfg.tx_start_enable;
            if (start_fall) begin
                tx_shift_q  <= TX_INIT_BYTE;
                tx_hold_q   <= TX_INIT_BYTE;
                hold_full_q <= 1'b1;
                tx_idx_q    <= '0;
                tx_bit      <= 1'b0;
            end else if (!sending) begin
                // before sending, a write pushes both registers along
                if (tx_write) begin
                    tx_shift_q <= tx_hold_q;
                    tx_hold_q  <= cmd_next[7:0];
                end
                if (start_rise) begin
                    hold_full_q <= 1'b1;
                end
                tx_idx_q <= '0;
            end else begin
                if (tx_bit_tick) begin
                    tx_bit   <= tx_shift_q[7];
                    tx_idx_q <= tx_idx_q + 3'h1;
                end
                if (reload) begin
                    tx_shift_q <= tx_hold_q;
                end else if (tx_bit_tick) begin
                    tx_shift_q <= {tx_shift_q[6:0], 1'b0};
                end
                if (tx_write) begin
                    tx_hold_q   <= cmd_next[7:0];
                    hold_full_q <= 1'b1;
                end else if (reload) begin
                    hold_full_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // status word and latched flags
    // ------------------------------------------------------------
    logic [4:0]   latch_q;
    logic [4:0]   latch_set;
    logic         stat_read_q;
    logic         clear_latched;
    logic         toggle_q;
    rfsb_status_t status_now;
    logic [STATUS_MSB:0] stat_sh_q;

    assign clear_latched = sel_end & stat_read_q;
    assign latch_set     = {1'b0, underrun_set, push & fifo_full,
                            wake_timer_ovf, ext_fall};

    // set wins over the clear at the end of a status read
    always_ff @(posedge mclk) begin
        if (rst) begin
            latch_q     <= LATCH_RESET;
            stat_read_q <= 1'b0;
            toggle_q    <= 1'b0;
        end else begin
            latch_q  <= latch_set | (latch_q & ~{5{clear_latched}});
            toggle_q <= toggle_q ^ afc_cycle_done;
            if (status_start) begin
                stat_read_q <= 1'b1;
            end else if (sel_end) begin
                stat_read_q <= 1'b0;
            end
        end
    end

    always_comb begin
        status_now.tx_ready_flag       = tx_ready;
        status_now.rx_level_flag       = rx_level_q;
        status_now.por_flag            = latch_q[4];
        status_now.tx_underrun_flag    = latch_q[3];
        status_now.rx_overflow_flag    = latch_q[2];
        status_now.wake_timer_flag     = latch_q[1];
        status_now.ext_pin_flag        = latch_q[0];
        status_now.low_supply_flag     = radio.low_supply;
        status_now.rx_empty_flag       = fifo_empty;
        status_now.antenna_signal_flag = radio.antenna_signal;
        status_now.rssi_flag           = radio.rssi_above;
        status_now.quality_detect_flag = radio.quality_detect;
        status_now.recovery_lock_flag  = radio.recovery_lock;
        status_now.offset_cycle_toggle = toggle_q;
        status_now.offset_sign         = freq_offset_field[6];
        status_now.offset_low          = freq_offset_field[3:0];
    end

    // ------------------------------------------------------------
    // serial data output
    // ------------------------------------------------------------
    logic idle_sdo;

    // fifo select wins over the ready indication while deselected
    assign idle_sdo = ffs_sel ? head_bit : tx_ready;

    always_ff @(posedge mclk) begin
        if (rst) begin
            sdo         <= 1'b0;
            stat_sh_q   <= '0;
            stat_left_q <= '0;
        end else if (!sel) begin
            sdo <= idle_sdo;
        end else if (status_start) begin
            sdo         <= status_now[STATUS_MSB];
            stat_sh_q   <= {status_now[STATUS_MSB-1:0], 1'b0};
            stat_left_q <= STATUS_LEFT;
        end else if (rise & (state_q == S_STAT) & (stat_left_q != '0)) begin
            sdo         <= stat_sh_q[STATUS_MSB];
            stat_sh_q   <= {stat_sh_q[STATUS_MSB-1:0], 1'b0};
            stat_left_q <= stat_left_q - 5'h01;
        end else if (serial_pop) begin
            sdo <= head_bit;
        end else if (state_q == S_CMD) begin
            sdo <= 1'b0;
        end
    end
endmodule

// File: rfsb_assertions.sv
// pin-level assertions for the radio status and buffer block
`timescale 1ns/1ns
module rfsb_assertions
    import rfsb_pkg::*;
(
    input wire logic                  mclk,
    input wire logic                  rst,
    input wire logic                  sck,
    input wire logic                  cmd_select_n,
    input wire logic                  fifo_select_n,
    input wire logic                  rx_bit_valid,
    input wire logic                  tx_bit_tick,
    input wire rfsb_pkg::rfsb_radio_t radio,
    input wire rfsb_pkg::rfsb_cfg_t   cfg,
    input wire logic                  sdo,
    input wire logic                  fifo_irq_n,
    input wire logic                  tx_bit
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire quiet = cmd_select_n && fifo_select_n && !cfg.tx_start_enable;
    // six cycles cover the pin synchronisers and the output register
    sequence on_idle_s;
        (quiet && cfg.tx_buffer_enable)[*6];
    endsequence
    sequence off_idle_s;
        (quiet && !cfg.tx_buffer_enable)[*6];
    endsequence
    sequence direct_s;
        (!fifo_select_n && cmd_select_n && !sck && !rx_bit_valid)[*8];
    endsequence
    reset_out_a: assert property ($fell(rst) |->
        !sdo && fifo_irq_n && !tx_bit) else $error("outputs off after reset");
    ready_idle_a: assert property (on_idle_s |-> sdo)
        else $error("sdo low while transmit register free");
    off_idle_a: assert property (off_idle_s |-> !sdo)
        else $error("sdo high with buffer disabled");
    // dropping tx start also clears the bit, so that edge is exempt
    tick_only_a: assert property (!$past(tx_bit_tick) &&
        $past(cfg.tx_start_enable) == $past(cfg.tx_start_enable, 2)
        |-> $stable(tx_bit)) else $error("tx bit moved without a tick");
    irq_cause_a: assert property ($fell(fifo_irq_n) |->
        $past(rx_bit_valid) || $past(rx_bit_valid, 2) ||
        $past(rx_bit_valid, 3)) else $error("fifo irq without a push");
    no_noise_a: assert property ((!radio.valid_data_indication)[*4]
        ##0 fifo_irq_n |=> fifo_irq_n) else $error("fifo filled on noise");
    direct_hold_a: assert property (direct_s |-> $stable(sdo))
        else $error("fifo head moved without a clock");
    // sdo drops to zero at frame start before any clock arrives
    frame_hold_a: assert property ($changed(sdo) && !cmd_select_n
        && !$past(cmd_select_n, 6) |-> $past(sck))
        else $error("sdo moved without a serial clock");
endmodule

// File: rfsb_host_model.sv
// host controller model driving the serial command and fifo pins
`timescale 1ns/1ns
module rfsb_host_model (
    input  wire logic mclk,
    input  wire logic sdo,
    output logic      sck,
    output logic      sdi,
    output logic      cmd_select_n,
    output logic      fifo_select_n
);
    initial begin
        sck           = 1'b0;
        sdi           = 1'b0;
        cmd_select_n  = 1'b1;
        fifo_select_n = 1'b1;
    end
    // sck period 8 mclk; sdo taken late in the low phase
    task automatic xfer(input logic [31:0] bits, input int n,
                        input logic direct, output logic [31:0] got);
        got = '0;
        @(posedge mclk);
        if (direct)
            fifo_select_n <= 1'b0;
        else
            cmd_select_n <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i <= n; i++) begin
            @(posedge mclk) sck <= 1'b0;
            if (i < n)
                sdi <= bits[n-1-i];
            repeat (2) @(posedge mclk);
            @(negedge mclk);
            if (direct ? i < n : i > 0)
                got = {got[30:0], sdo};
            if (i < n) begin
                repeat (2) @(posedge mclk);
                sck <= 1'b1;
                repeat (3) @(posedge mclk);
            end
        end
        @(posedge mclk) cmd_select_n <= 1'b1;
        fifo_select_n <= 1'b1;
        // released line must not keep its last value
        sdi <= ~sdi;
        repeat (6) @(posedge mclk);
    endtask
endmodule

// File: testbench.sv
// self-checking bench: status reads, buffered transmit, receive fifo
`timescale 1ns/1ns
module testbench;
    import rfsb_pkg::*;
    logic         mclk, rst, sck, sdi, cmd_select_n, fifo_select_n;
    logic         ext_irq_n, afc_cycle_done, wake_timer_ovf, tx_bit_tick;
    logic         rx_bit_valid, rx_bit, sdo, fifo_irq_n, tx_bit;
    logic [6:0]   freq_offset_field;
    logic [31:0]  got;
    rfsb_radio_t  radio;
    rfsb_cfg_t    cfg;
    rfsb_status_t st;
    int           err_count = 0;
    int           total_checks = 0;

    rfsb_top DUT (.mclk, .rst, .sck, .sdi, .cmd_select_n, .fifo_select_n,
        .ext_irq_n, .radio, .freq_offset_field, .afc_cycle_done,
        .wake_timer_ovf, .rx_bit_valid, .rx_bit, .tx_bit_tick, .cfg,
        .sdo, .fifo_irq_n, .tx_bit);
    rfsb_host_model host (.mclk, .sdo, .sck, .sdi, .cmd_select_n,
        .fifo_select_n);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, seen, want);
        end
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic settle;
        repeat (4) @(posedge mclk);
        @(negedge mclk);
    endtask

    task automatic stat;
        host.xfer(32'h0, 19, 1'b0, got);
        check(got, {13'h0, st});
    endtask

    task automatic txb(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            @(posedge mclk) tx_bit_tick <= 1'b1;
            @(posedge mclk) tx_bit_tick <= 1'b0;
            @(negedge mclk) check(32'(tx_bit), 32'(b[i]));
        end
    endtask

    task automatic push(input logic b);
        @(posedge mclk) rx_bit_valid <= 1'b1;
        rx_bit <= b;
        @(posedge mclk) rx_bit_valid <= 1'b0;
    endtask

    initial begin
        {rst, ext_irq_n} = 2'b11;
        {afc_cycle_done, wake_timer_ovf, tx_bit_tick} = 3'h0;
        {rx_bit_valid, rx_bit} = 2'h0;
        radio = 7'h58; // supply low, rssi, quality
        cfg = 6'h01;
        freq_offset_field = 7'h56;
        // por, supply, empty, rssi, quality, sign 1, offset 6
        st = 19'h10d96;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        repeat (4) @(posedge mclk);
        stat();
        @(posedge mclk) ext_irq_n <= 1'b0;
        {wake_timer_ovf, afc_cycle_done} <= 2'h3;
        @(posedge mclk) {wake_timer_ovf, afc_cycle_done} <= 2'h0;
        st.por_flag = 1'b0;
        {st.wake_timer_flag, st.ext_pin_flag} = 2'h3;
        st.offset_cycle_toggle = 1'b1;
        stat();
        {st.wake_timer_flag, st.ext_pin_flag} = 2'h0;
        stat();
        host.xfer(32'hb855, 16, 1'b0, got);
        @(posedge mclk) cfg.tx_buffer_enable <= 1'b1;
        settle();
        check(32'(sdo), 32'h1);
        @(posedge mclk) cfg.tx_start_enable <= 1'b1;
        txb(8'haa);
        settle();
        check(32'(sdo), 32'h1);
        host.xfer(32'hb83c, 16, 1'b0, got);
        settle();
        check(32'(sdo), 32'h0);
        txb(8'haa);
        txb(8'h3c);
        @(posedge mclk) cfg.tx_start_enable <= 1'b0;
        repeat (2) @(posedge mclk);
        cfg.tx_start_enable <= 1'b1;
        txb(8'haa);
        @(posedge mclk) cfg <= 6'h01;
        push(1'b1);
        @(posedge mclk) radio <= 7'h5b;
        repeat (2) @(posedge mclk);
        push(1'b1);
        push(1'b0);
        push(1'b1);
        settle();
        check(32'(fifo_irq_n), 32'h0);
        {st.rx_level_flag, st.rx_empty_flag, st.tx_underrun_flag} = 3'b101;
        stat();
        host.xfer(32'h0, 4, 1'b1, got);
        check(got, 32'ha);
        settle();
        check(32'(fifo_irq_n), 32'h1);
        push(1'b1);
        push(1'b0);
        host.xfer(32'h2c000, 18, 1'b0, got);
        check(got, 32'h2);
        {st.rx_level_flag, st.rx_empty_flag, st.tx_underrun_flag} = 3'b010;
        stat();
        summarize();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        err_count++;
        summarize();
    end
endmodule

bind rfsb_top rfsb_assertions chk (.mclk, .rst, .sck, .cmd_select_n,
    .fifo_select_n, .rx_bit_valid, .tx_bit_tick, .radio, .cfg, .sdo,
    .fifo_irq_n, .tx_bit);
